// ### verilog/interrupt_priority_defs.vh
// Constants for the interrupt priority register slice and its bus slave
`ifndef INTERRUPT_PRIORITY_DEFS_VH
`define INTERRUPT_PRIORITY_DEFS_VH

// Register byte offsets within the slave window
`define ADDR_W              12
`define OFFS_I2C2_PRIO      12'h000
`define OFFS_CLOCK_PRIO     12'h004

// Priority field geometry and encoding
`define LVL_W               3
`define MST_LSB             8
`define SLV_LSB             4
`define CLK_LSB             8
`define LVL_RESET           3'h4
`define LVL_OFF             3'h0
`define LVL_MIN             3'h1
`define LVL_MAX             3'h7

// Byte lanes that hold each field
`define MST_LANE            1
`define SLV_LANE            0
`define CLK_LANE            1

// AHB-Lite encodings
`define HTRANS_NONSEQ_BIT   1
`define HSIZE_BYTE          3'h0
`define HSIZE_HALF          3'h1
`define HRESP_OKAY          1'b0
`define LANES_ALL           4'hF
`define LANES_LOW_HALF      4'h3
`define LANES_HIGH_HALF     4'hC
`define LANE_ONE            4'h1
`define DATA_ZERO           32'h0000_0000

// Source identifiers on the winner output
`define SRC_W               2
`define SRC_NONE            2'h0
`define SRC_MST             2'h1
`define SRC_SLV             2'h2
`define SRC_CLK             2'h3

`endif

// ### verilog/priority_field.v
// One software-written 3-bit interrupt priority field
`timescale 1ns/1ps
`include "interrupt_priority_defs.vh"

module priority_field
(
   // Clock and reset
   input  wire                hclk,
   input  wire                hresetn,
   // Write port
   input  wire                wr_en,
   input  wire [`LVL_W-1:0]   wr_level,
   // Field state
   output wire [`LVL_W-1:0]   level,
   output wire                serviceable,
   output wire                at_max
);

   reg [`LVL_W-1:0] level_q;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         level_q <= `LVL_RESET;
      else if (wr_en)
         level_q <= wr_level;
   end

   assign level       = level_q;
   // Code zero takes the source out of servicing entirely
   assign serviceable = (level_q != `LVL_OFF); // R5
   assign at_max      = (level_q == `LVL_MAX); // R3

endmodule

// ### verilog/interrupt_priority_regs_i2c_rtc.v
// Priority registers for second I2C and clock/calendar events, with an AHB-Lite slave
//
// Notes on behaviour
// R1: Bits 10 to 8 of the I2C priority register hold the writable master event level.
// R2: Bits 6 to 4 of the same register hold the writable slave event level.
// R3: Code 111 gives level 7, the highest, and smaller codes give proportionally lower levels.
// R4: Code 001 gives level 1, the lowest level that is still serviced.
// R5: Code 000 disables the source, so it is never presented whatever its request.
// R6: A second register holds the clock/calendar level at bits 10 to 8; unused bits read zero, ignore writes.
`timescale 1ns/1ps
`include "interrupt_priority_defs.vh"

module interrupt_priority_regs_i2c_rtc
(
   // Clock and reset
   input  wire                hclk,
   input  wire                hresetn,
   // AHB-Lite slave
   input  wire                hsel,
   input  wire [31:0]         haddr,
   input  wire [1:0]          htrans,
   input  wire                hwrite,
   input  wire [2:0]          hsize,
   input  wire                hready,
   input  wire [31:0]         hwdata,
   output wire [31:0]         hrdata,
   output wire                hreadyout,
   output wire                hresp,
   // Event requests (flag and enable already combined)
   input  wire                master_event_req,
   input  wire                slave_event_req,
   input  wire                clock_event_req,
   // Levels to the arbitration logic
   output wire [`LVL_W-1:0]   second_i2c_master_event_level,
   output wire [`LVL_W-1:0]   second_i2c_slave_event_level,
   output wire [`LVL_W-1:0]   clock_calendar_event_level,
   // Presented request and its winner
   output wire                master_event_presented,
   output wire                slave_event_presented,
   output wire                clock_event_presented,
   output wire [`SRC_W-1:0]   winner_source,
   output wire [`LVL_W-1:0]   winner_level
);

   // Byte lanes touched by a transfer of the given size and address
   function [3:0] lanes_of;
      input [2:0] size;
      input [1:0] addr_lo;
      begin
         if (size == `HSIZE_BYTE)
            lanes_of = `LANE_ONE << addr_lo;
         else if (size == `HSIZE_HALF)
            lanes_of = addr_lo[1] ? `LANES_HIGH_HALF : `LANES_LOW_HALF;
         else
            lanes_of = `LANES_ALL;
      end
   endfunction

   // Register image with unimplemented bits forced to zero
   function [31:0] i2c_image;
      input [`LVL_W-1:0] mst;
      input [`LVL_W-1:0] slv;
      begin
         i2c_image = `DATA_ZERO;
         i2c_image[`MST_LSB +: `LVL_W] = mst; // R1
         i2c_image[`SLV_LSB +: `LVL_W] = slv; // R2
      end
   endfunction

   function [31:0] clock_image;
      input [`LVL_W-1:0] clk_lvl;
      begin
         clock_image = `DATA_ZERO;
         clock_image[`CLK_LSB +: `LVL_W] = clk_lvl; // R6
      end
   endfunction

   // Address phase capture
   reg                  wr_pend_q;
   reg [`ADDR_W-1:0]    wr_addr_q;
   reg [3:0]            wr_lanes_q;
   reg [31:0]           hrdata_q;
   reg [31:0]           hrdata_d;

   wire                 addr_phase;
   wire [3:0]           lanes_now;

   assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
   assign lanes_now  = lanes_of(hsize, haddr[1:0]);

   // Data phase writes, per field, honouring byte lanes
   wire                 hit_i2c;
   wire                 hit_clk;
   wire                 we_mst;
   wire                 we_slv;
   wire                 we_clk;

   assign hit_i2c = wr_pend_q & (wr_addr_q == `OFFS_I2C2_PRIO);
   assign hit_clk = wr_pend_q & (wr_addr_q == `OFFS_CLOCK_PRIO);
   assign we_mst  = hit_i2c & wr_lanes_q[`MST_LANE]; // R1
   assign we_slv  = hit_i2c & wr_lanes_q[`SLV_LANE]; // R2
   assign we_clk  = hit_clk & wr_lanes_q[`CLK_LANE]; // R6

   wire [`LVL_W-1:0]    mst_level;
   wire [`LVL_W-1:0]    slv_level;
   wire [`LVL_W-1:0]    clk_level;
   wire                 mst_on;
   wire                 slv_on;
   wire                 clk_on;

   priority_field u_mst
   (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .wr_en       (we_mst),
      .wr_level    (hwdata[`MST_LSB +: `LVL_W]),
      .level       (mst_level),
      .serviceable (mst_on),
      .at_max      ()
   );

   priority_field u_slv
   (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .wr_en       (we_slv),
      .wr_level    (hwdata[`SLV_LSB +: `LVL_W]),
      .level       (slv_level),
      .serviceable (slv_on),
      .at_max      ()
   );

   priority_field u_clk
   (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .wr_en       (we_clk),
      .wr_level    (hwdata[`CLK_LSB +: `LVL_W]),
      .level       (clk_level),
      .serviceable (clk_on),
      .at_max      ()
   );

   // Forward a write still in its data phase so a back-to-back read sees it
   wire [`LVL_W-1:0]    mst_fwd;
   wire [`LVL_W-1:0]    slv_fwd;
   wire [`LVL_W-1:0]    clk_fwd;

   assign mst_fwd = we_mst ? hwdata[`MST_LSB +: `LVL_W] : mst_level;
   assign slv_fwd = we_slv ? hwdata[`SLV_LSB +: `LVL_W] : slv_level;
   assign clk_fwd = we_clk ? hwdata[`CLK_LSB +: `LVL_W] : clk_level;

   always @*
   begin
      hrdata_d = hrdata_q;
      if (addr_phase && !hwrite)
      begin
         // Unmapped offsets read as zero with an OKAY answer
         if (haddr[`ADDR_W-1:0] == `OFFS_I2C2_PRIO)
            hrdata_d = i2c_image(mst_fwd, slv_fwd);
         else if (haddr[`ADDR_W-1:0] == `OFFS_CLOCK_PRIO)
            hrdata_d = clock_image(clk_fwd);
         else
            hrdata_d = `DATA_ZERO;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q  <= 1'b0;
         wr_addr_q  <= {`ADDR_W{1'b0}};
         wr_lanes_q <= 4'h0;
         hrdata_q   <= `DATA_ZERO;
      end
      else
      begin
         hrdata_q <= hrdata_d;
         if (hready)
         begin
            wr_pend_q  <= addr_phase & hwrite;
            wr_addr_q  <= haddr[`ADDR_W-1:0];
            wr_lanes_q <= lanes_now;
         end
      end
   end

   // Zero wait states; every transfer completes OKAY
   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = `HRESP_OKAY;

   assign second_i2c_master_event_level = mst_level;
   assign second_i2c_slave_event_level  = slv_level;
   assign clock_calendar_event_level    = clk_level;

   // Presentation and winner selection
   wire                 mst_pres;
   wire                 slv_pres;
   wire                 clk_pres;

   assign mst_pres = master_event_req & mst_on; // R5
   assign slv_pres = slave_event_req  & slv_on; // R5
   assign clk_pres = clock_event_req  & clk_on; // R5

   reg                  mst_pres_q;
   reg                  slv_pres_q;
   reg                  clk_pres_q;
   reg [`SRC_W-1:0]     win_src_q;
   reg [`SRC_W-1:0]     win_src_d;
   reg [`LVL_W-1:0]     win_lvl_q;
   reg [`LVL_W-1:0]     win_lvl_d;

   // Higher code wins; equal codes fall back to master, slave, clock order.
   // Strict greater-than keeps the earlier source on a tie.
   always @*
   begin
      win_src_d = `SRC_NONE;
      win_lvl_d = `LVL_OFF;
      if (mst_pres)
      begin
         win_src_d = `SRC_MST;
         win_lvl_d = mst_level; // R3
      end
      if (slv_pres && (slv_level > win_lvl_d))
      begin
         win_src_d = `SRC_SLV;
         win_lvl_d = slv_level; // R3
      end
      if (clk_pres && (clk_level > win_lvl_d))
      begin
         win_src_d = `SRC_CLK;
         win_lvl_d = clk_level; // R3
      end
      // A presented source has at least level 1, so it always beats none
      if (win_src_d == `SRC_NONE)
         win_lvl_d = `LVL_OFF; // R4
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mst_pres_q <= 1'b0;
         slv_pres_q <= 1'b0;
         clk_pres_q <= 1'b0;
         win_src_q  <= `SRC_NONE;
         win_lvl_q  <= `LVL_OFF;
      end
      else
      begin
         mst_pres_q <= mst_pres;
         slv_pres_q <= slv_pres;
         clk_pres_q <= clk_pres;
         win_src_q  <= win_src_d;
         win_lvl_q  <= win_lvl_d;
      end
   end

   assign master_event_presented = mst_pres_q;
   assign slave_event_presented  = slv_pres_q;
   assign clock_event_presented  = clk_pres_q;
   assign winner_source          = win_src_q;
   assign winner_level           = win_lvl_q;

endmodule

// ### tb/interrupt_priority_regs_i2c_rtc_chk.sv
// Concurrent assertions on the ports of the priority register slice
`timescale 1ns/1ps
module interrupt_priority_regs_i2c_rtc_chk
(
   // Clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // Bus
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   // Levels and arbitration
   input wire logic        master_event_req,
   input wire logic [2:0]  second_i2c_master_event_level,
   input wire logic [2:0]  second_i2c_slave_event_level,
   input wire logic [2:0]  clock_calendar_event_level,
   input wire logic        master_event_presented,
   input wire logic        slave_event_presented,
   input wire logic [2:0]  winner_level
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Whole-word transfer taken at this edge
   sequence s_req(logic w, logic [11:0] a);
      hsel && hready && htrans[1] && hwrite == w && haddr[11:0] == a && hsize == 3'h2;
   endsequence

   property p_wr_mst;
      s_req(1'b1, 12'h000) |=> ##1 second_i2c_master_event_level == $past(hwdata[10:8]);
   endproperty
   a_wr_mst: assert property (p_wr_mst) else $error("master level not written");
   property p_wr_slv;
      s_req(1'b1, 12'h000) |=> ##1 second_i2c_slave_event_level == $past(hwdata[6:4]);
   endproperty
   a_wr_slv: assert property (p_wr_slv) else $error("slave level not written");
   property p_wr_clk;
      s_req(1'b1, 12'h004) |=> ##1 clock_calendar_event_level == $past(hwdata[10:8]);
   endproperty
   a_wr_clk: assert property (p_wr_clk) else $error("clock level not written");
   property p_rd_map;
      s_req(1'b0, 12'h000) |=> hrdata == {21'h0, second_i2c_master_event_level, 1'b0,
                                          second_i2c_slave_event_level, 4'h0};
   endproperty
   a_rd_map: assert property (p_rd_map) else $error("i2c register read wrong");
   property p_rd_clk;
      s_req(1'b0, 12'h004) |=> hrdata == {21'h0, clock_calendar_event_level, 8'h00};
   endproperty
   a_rd_clk: assert property (p_rd_clk) else $error("clock register read wrong");
   property p_top;
      master_event_req && second_i2c_master_event_level == 3'h7 |=> winner_level == 3'h7;
   endproperty
   a_top: assert property (p_top) else $error("level seven did not win");
   property p_pres;
      master_event_req && second_i2c_master_event_level != 3'h0 |=> master_event_presented;
   endproperty
   a_pres: assert property (p_pres) else $error("enabled source not presented");
   property p_off;
      second_i2c_slave_event_level == 3'h0 |=> !slave_event_presented;
   endproperty
   a_off: assert property (p_off) else $error("disabled source presented");
endmodule

bind interrupt_priority_regs_i2c_rtc interrupt_priority_regs_i2c_rtc_chk interrupt_priority_regs_i2c_rtc_chk_i (.*);

// ### tb/interrupt_priority_regs_i2c_rtc_tb.sv
// Self-checking bench for the priority register slice
`timescale 1ns/1ps
module interrupt_priority_regs_i2c_rtc_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        mreq = 1'b0;
   logic        sreq = 1'b0;
   logic        creq = 1'b0;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, mp, sp, cp;
   wire  [2:0]  ml, sl, cl, wl;
   wire  [1:0]  ws;
   int          failures = 0;
   int          cmp_count = 0;

   always #5 hclk = ~hclk;

   interrupt_priority_regs_i2c_rtc interrupt_priority_regs_i2c_rtc_i
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .master_event_req(mreq), .slave_event_req(sreq),
      .clock_event_req(creq), .second_i2c_master_event_level(ml), .second_i2c_slave_event_level(sl),
      .clock_calendar_event_level(cl), .master_event_presented(mp), .slave_event_presented(sp),
      .clock_event_presented(cp), .winner_source(ws), .winner_level(wl)
   );

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Bounded wait so a stuck slave cannot hang the run
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge hclk);
      end
      if (n == 20)
      begin
         failures++;
         end_sim();
      end
   endtask

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      htrans <= 2'h2;
      hsel   <= 1'b1;
      hwrite <= w;
      haddr  <= {20'h0, a};
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(1'b0, a, 32'hA5A5_5A5A, r);
      check(name, r, exp);
   endtask

   task automatic test_reset;
      rd("i2c reg", 12'h000, 32'h0000_0440);
      rd("clock reg", 12'h004, 32'h0000_0400);
      $display("test_reset done");
   endtask

   // Every code in every field, with all unused bits written as ones
   task automatic test_codes;
      for (int v = 0; v < 8; v++)
      begin
         wr(12'h000, 32'hFFFF_F88F | (v << 8) | ((7 - v) << 4));
         rd("i2c reg", 12'h000, (v << 8) | ((7 - v) << 4));
         check("master level", ml, v);
         check("slave level", sl, 7 - v);
         wr(12'h004, 32'hFFFF_F8FF | (v << 8));
         rd("clock reg", 12'h004, v << 8);
         check("clock level", cl, v);
      end
      wr(12'h008, 32'hFFFF_FFFF);
      rd("unmapped", 12'h008, 32'h0);
      check("unmapped answer", hresp, 0);
      rd("i2c kept", 12'h000, 32'h0000_0700);
      $display("test_codes done");
   endtask

   task automatic test_arb;
      wr(12'h000, 32'h0000_0100);
      wr(12'h004, 32'h0000_0700);
      mreq <= 1'b1;
      sreq <= 1'b1;
      creq <= 1'b1;
      repeat (2) @(posedge hclk);
      check("master shown", mp, 1);
      check("slave shown", sp, 0);
      check("winner level", wl, 7);
      check("winner source", ws, 3);
      wr(12'h004, 32'h0);
      repeat (2) @(posedge hclk);
      check("clock shown", cp, 0);
      check("low winner", wl, 1);
      check("low source", ws, 1);
      // Equal top levels on master and clock: the master keeps the win
      wr(12'h004, 32'h0000_0700);
      wr(12'h000, 32'h0000_0700);
      repeat (2) @(posedge hclk);
      check("top level", wl, 7);
      check("tie source", ws, 1);
      check("clock shown", cp, 1);
      mreq <= 1'b0;
      sreq <= 1'b0;
      creq <= 1'b0;
      $display("test_arb done");
   endtask

   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      test_reset();
      test_codes();
      test_arb();
      end_sim();
   end
endmodule
